// File: pcu_regs.svh
// Purpose: register offsets, field positions and reset values of the counter unit
// Assumes: APB byte addresses, 32-bit aligned words
// Notes: definitions only
`ifndef PCU_REGS_SVH
`define PCU_REGS_SVH

`define PCU_CTRL_BASE 8'h00
`define PCU_CNT_BASE 8'h04
`define PCU_CHAN_STRIDE 8'h08
`define PCU_STATUS_OFS 8'h20
`define PCU_ADDR_MASK 8'hFC

`define PCU_SEL_LO 0
`define PCU_SEL_W 5
`define PCU_START_LO 8
`define PCU_END_LO 16
`define PCU_TRIG_W 4

`define PCU_CTRL_RST 32'h0000_0000
`define PCU_CNT_RST 32'h0000_0000

`define PCU_TRIG_NONE 4'h0
`define PCU_TRIG_LOW_MAX 4'h6
`define PCU_TRIG_HOLE 4'h7
`define PCU_TRIG_HIGH_MAX 4'hC
`define PCU_TRIG_CH8 4'h8
`define PCU_TRIG_CH9 4'h9

`define PCU_STAT_RUN_LO 0
`define PCU_STAT_DONE_LO 4
`define PCU_STAT_BAD_LO 8
`define PCU_STAT_STEP 12

`endif

// File: pcu_pkg.sv
// Purpose: types shared by the performance counter unit
// Assumes: nothing
// Notes: constants live in pcu_regs.svh
package pcu_pkg;

    typedef enum logic [4:0] {
        SEL_OFF = 5'h00,
        SEL_ELAPSED = 5'h01,
        SEL_PRIV = 5'h02,
        SEL_MASKED = 5'h03,
        SEL_INSN = 5'h04,
        SEL_DUAL = 5'h05,
        SEL_BRANCH = 5'h06,
        SEL_EXC = 5'h07,
        SEL_IRQ = 5'h08,
        SEL_BREAK = 5'h09,
        SEL_STALL_MULTI = 5'h0A,
        SEL_STALL_SINGLE = 5'h0B,
        SEL_TLB_FETCH = 5'h0C,
        SEL_TLB_OPERAND = 5'h0D,
        SEL_FETCH_TLB = 5'h0E,
        SEL_FETCH_ACC = 5'h0F,
        SEL_ICACHE = 5'h10
    } pcu_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_COUNT = 2'b10,
        ST_DONE = 2'b11
    } pcu_state_t;

    typedef enum logic [1:0] {
        MODE_AUTO = 2'b00,
        MODE_TRIG = 2'b01,
        MODE_BAD = 2'b10
    } pcu_mode_t;

endpackage

// File: pcu_evt_if.sv
// Purpose: processor event bundle carried from the top to the event selectors
// Assumes: all signals synchronous to pclk, one-cycle pulses or levels
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface pcu_evt_if;
    logic power_on_busy;
    logic priv_mode;
    logic exception_mask_bit;
    logic insn_done;
    logic dual_issue;
    logic uncond_branch;
    logic branch_by_exc;
    logic exception_return;
    logic exc_accept;
    logic irq_accept;
    logic nmi_accept;
    logic [3:0] break_hit;
    logic full_trace;
    logic [3:0] stall_src;
    logic stall_exec;
    logic evc_update;
    logic evc_tlb_fetch;
    logic evc_tlb_operand;
    logic ftlb_miss;
    logic ftlb_valid;
    logic fetch_access;
    logic fetch_cancel;
    logic icache_access;

    modport src (output power_on_busy, priv_mode, exception_mask_bit, insn_done, dual_issue,
        uncond_branch, branch_by_exc, exception_return, exc_accept, irq_accept, nmi_accept,
        break_hit, full_trace, stall_src, stall_exec, evc_update, evc_tlb_fetch,
        evc_tlb_operand, ftlb_miss, ftlb_valid, fetch_access, fetch_cancel, icache_access);
    modport sink (input power_on_busy, priv_mode, exception_mask_bit, insn_done, dual_issue,
        uncond_branch, branch_by_exc, exception_return, exc_accept, irq_accept, nmi_accept,
        break_hit, full_trace, stall_src, stall_exec, evc_update, evc_tlb_fetch,
        evc_tlb_operand, ftlb_miss, ftlb_valid, fetch_access, fetch_cancel, icache_access);
endinterface
`default_nettype wire

// File: pcu_event_sel.sv
// Purpose: turns the selected event class into a per-cycle increment
// Assumes: event inputs are qualified by the core
// Notes: combinational, increment at most four per cycle
`timescale 1ns/1ps
`default_nettype none
module pcu_event_sel (
    input wire logic pclk,
    input wire logic presetn,
    pcu_evt_if.sink evt,
    input wire pcu_pkg::pcu_sel_t sel,
    output logic [2:0] inc
);
    logic [2:0] stall_pop;
    logic elapsed;

    // power-on cycles are never counted as elapsed
    assign elapsed = ~evt.power_on_busy;
    assign stall_pop = 3'({2'b00, evt.stall_src[0]} + {2'b00, evt.stall_src[1]}
        + {2'b00, evt.stall_src[2]} + {2'b00, evt.stall_src[3]});

    always_comb begin
        inc = 3'h0;
        case (sel)
            pcu_pkg::SEL_ELAPSED: inc = {2'b00, elapsed};
            pcu_pkg::SEL_PRIV: inc = {2'b00, elapsed & evt.priv_mode};
            pcu_pkg::SEL_MASKED: inc = {2'b00, elapsed & evt.exception_mask_bit};
            pcu_pkg::SEL_INSN: inc = {1'b0, evt.insn_done & evt.dual_issue,
                evt.insn_done ^ evt.dual_issue};
            pcu_pkg::SEL_DUAL: inc = {2'b00, evt.dual_issue};
            pcu_pkg::SEL_BRANCH: inc = {2'b00, (evt.uncond_branch & ~evt.branch_by_exc)
                | evt.exception_return};
            pcu_pkg::SEL_EXC: inc = {2'b00, evt.exc_accept | evt.irq_accept
                | evt.nmi_accept};
            pcu_pkg::SEL_IRQ: inc = {2'b00, evt.irq_accept | evt.nmi_accept};
            pcu_pkg::SEL_BREAK: inc = {2'b00, |evt.break_hit};
            pcu_pkg::SEL_STALL_MULTI: inc = evt.full_trace ? stall_pop : 3'h0;
            pcu_pkg::SEL_STALL_SINGLE: inc = {2'b00, evt.full_trace & (|evt.stall_src)
                & ~evt.stall_exec};
            pcu_pkg::SEL_TLB_FETCH: inc = {2'b00, evt.evc_update & evt.evc_tlb_fetch};
            pcu_pkg::SEL_TLB_OPERAND: inc = {2'b00, evt.evc_update
                & evt.evc_tlb_operand};
            pcu_pkg::SEL_FETCH_TLB: inc = {2'b00, evt.ftlb_miss & evt.ftlb_valid};
            pcu_pkg::SEL_FETCH_ACC: inc = {2'b00, evt.fetch_access
                & ~evt.fetch_cancel};
            pcu_pkg::SEL_ICACHE: inc = {2'b00, evt.icache_access};
            default: inc = 3'h0;
        endcase
    end

    a_break_or: assert property (@(posedge pclk) disable iff (!presetn)
        sel == pcu_pkg::SEL_BREAK |-> inc == {2'b00, |evt.break_hit})
        else $error("break hits not ored into one count");
    a_single_skip: assert property (@(posedge pclk) disable iff (!presetn)
        (sel == pcu_pkg::SEL_STALL_SINGLE && evt.stall_exec) |-> inc == 3'h0)
        else $error("single stall counted during execution stall");
    a_multi_count: assert property (@(posedge pclk) disable iff (!presetn)
        (sel == pcu_pkg::SEL_STALL_MULTI && evt.full_trace)
        |-> inc == 3'($countones(evt.stall_src)))
        else $error("coinciding stall sources not counted apiece");
endmodule
`default_nettype wire

// File: pcu_top.sv
// Purpose: four-channel processor performance counter with APB registers
// Assumes: event inputs synchronous to pclk; event conditions arrive as levels
// Notes: counts freeze at the end trigger until software reads them
`timescale 1ns/1ps
`default_nettype none
`include "pcu_regs.svh"

// Behaviour
// - no triggers: run-start to any condition
// - only one trigger set: channel measures nothing
// - configured triggers on an enabled channel forbid single-step execution
// - four channels, triggers from conditions 1-6, 8-12
// - channels one and two refuse conditions 8, 9
// - four channels at once; disabled selection counts nothing
// - elapsed cycles, power-on period excluded
// - elapsed cycles in privileged mode only
// - elapsed cycles with exception mask bit set
// - completed instructions plus dual-issue cycles
// - one count per dual-issue cycle
// - unconditional branches, not exception entries, plus returns
// - exceptions with interrupts; interrupts with non-maskable
// - any break channel hit counts once
// - full-trace stalls, each source counted apart
// - full-trace stall skipped during execution stall
// - fetch translation-miss exceptions per event-code update
// - operand translation-miss exceptions per event-code update
// - fetch buffer misses on valid accesses only
// - fetch accesses incl. speculative, prefetch; cancelled excluded
// - instruction cache accesses during opcode fetch
module pcu_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic exec_start,
    input wire logic [12:0] evcond,
    input wire logic power_on_busy,
    input wire logic priv_mode,
    input wire logic exception_mask_bit,
    input wire logic insn_done,
    input wire logic dual_issue,
    input wire logic uncond_branch,
    input wire logic branch_by_exc,
    input wire logic exception_return,
    input wire logic exc_accept,
    input wire logic irq_accept,
    input wire logic nmi_accept,
    input wire logic [3:0] break_hit,
    input wire logic full_trace,
    input wire logic [3:0] stall_src,
    input wire logic stall_exec,
    input wire logic evc_update,
    input wire logic evc_tlb_fetch,
    input wire logic evc_tlb_operand,
    input wire logic ftlb_miss,
    input wire logic ftlb_valid,
    input wire logic fetch_access,
    input wire logic fetch_cancel,
    input wire logic icache_access,
    output logic step_inhibit
);
    localparam int NCH = 4;

    pcu_evt_if evt ();

    logic [31:0] ctrl [NCH];
    logic [31:0] cnt [NCH];
    pcu_pkg::pcu_state_t st [NCH];
    pcu_pkg::pcu_mode_t mode [NCH];
    pcu_pkg::pcu_sel_t sel [NCH];
    logic [2:0] inc [NCH];
    logic [NCH-1:0] ctrl_wr;
    logic [NCH-1:0] cnt_rd;
    logic [NCH-1:0] start_go;
    logic [NCH-1:0] end_go;
    logic [NCH-1:0] trig_cfg;
    logic [NCH-1:0] bad_cfg;
    logic apb_done;
    logic [31:0] next_rdata;
    logic next_err;

    assign evt.power_on_busy = power_on_busy;
    assign evt.priv_mode = priv_mode;
    assign evt.exception_mask_bit = exception_mask_bit;
    assign evt.insn_done = insn_done;
    assign evt.dual_issue = dual_issue;
    assign evt.uncond_branch = uncond_branch;
    assign evt.branch_by_exc = branch_by_exc;
    assign evt.exception_return = exception_return;
    assign evt.exc_accept = exc_accept;
    assign evt.irq_accept = irq_accept;
    assign evt.nmi_accept = nmi_accept;
    assign evt.break_hit = break_hit;
    assign evt.full_trace = full_trace;
    assign evt.stall_src = stall_src;
    assign evt.stall_exec = stall_exec;
    assign evt.evc_update = evc_update;
    assign evt.evc_tlb_fetch = evc_tlb_fetch;
    assign evt.evc_tlb_operand = evc_tlb_operand;
    assign evt.ftlb_miss = ftlb_miss;
    assign evt.ftlb_valid = ftlb_valid;
    assign evt.fetch_access = fetch_access;
    assign evt.fetch_cancel = fetch_cancel;
    assign evt.icache_access = icache_access;

    // trigger code legal for a channel; 0 means none configured
    function automatic logic trig_legal(input int ch, input logic [3:0] code);
        logic ok;
        ok = (code != `PCU_TRIG_NONE) && (code != `PCU_TRIG_HOLE)
            && (code <= `PCU_TRIG_HIGH_MAX);
        if (ch < 2 && (code == `PCU_TRIG_CH8 || code == `PCU_TRIG_CH9)) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    function automatic pcu_pkg::pcu_mode_t trig_mode(input int ch, input logic [31:0] c);
        logic [3:0] s;
        logic [3:0] e;
        s = c[`PCU_START_LO +: `PCU_TRIG_W];
        e = c[`PCU_END_LO +: `PCU_TRIG_W];
        if (s == `PCU_TRIG_NONE && e == `PCU_TRIG_NONE) begin
            return pcu_pkg::MODE_AUTO;
        end else if (trig_legal(ch, s) && trig_legal(ch, e)) begin
            return pcu_pkg::MODE_TRIG;
        end else begin
            return pcu_pkg::MODE_BAD;
        end
    endfunction

    // address decode: 0 none, 1 control, 2 count, 3 status; chan gives the channel
    function automatic logic [1:0] addr_kind(input logic [7:0] a);
        logic [7:0] w;
        w = a & `PCU_ADDR_MASK;
        if (a[1:0] != 2'b00) begin
            return 2'h0;
        end else if (w == `PCU_STATUS_OFS) begin
            return 2'h3;
        end else if (w < `PCU_STATUS_OFS && w[2] == 1'b0) begin
            return 2'h1;
        end else if (w < `PCU_STATUS_OFS) begin
            return 2'h2;
        end else begin
            return 2'h0;
        end
    endfunction

    function automatic logic [1:0] addr_chan(input logic [7:0] a);
        return a[4:3];
    endfunction

    // one wait state keeps read data a clean flop output
    assign apb_done = psel & penable & pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    // status is side-effect free, so software may poll it
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        case (addr_kind(paddr))
            2'h1: next_rdata = ctrl[addr_chan(paddr)];
            2'h2: next_rdata = cnt[addr_chan(paddr)];
            2'h3: begin
                for (int i = 0; i < NCH; i++) begin
                    next_rdata[`PCU_STAT_RUN_LO + i] = (st[i] == pcu_pkg::ST_COUNT);
                    next_rdata[`PCU_STAT_DONE_LO + i] = (st[i] == pcu_pkg::ST_DONE);
                    next_rdata[`PCU_STAT_BAD_LO + i] = bad_cfg[i];
                end
                next_rdata[`PCU_STAT_STEP] = step_inhibit;
            end
            default: next_err = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= next_err;
        end else begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // single-step is refused while any enabled channel has triggers configured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_inhibit <= 1'b0;
        end else begin
            step_inhibit <= |trig_cfg;
        end
    end

    a_step_block: assert property (@(posedge pclk) disable iff (!presetn)
        (|trig_cfg) |=> step_inhibit)
        else $error("single step not inhibited with triggers set");
    a_step_free: assert property (@(posedge pclk) disable iff (!presetn)
        !(|trig_cfg) |=> !step_inhibit)
        else $error("step inhibited without triggers");

    a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready)
        else $error("apb answer late");

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_chan
            assign ctrl_wr[g] = apb_done & pwrite & (addr_kind(paddr) == 2'h1)
                & (addr_chan(paddr) == 2'(g));
            assign cnt_rd[g] = apb_done & ~pwrite & (addr_kind(paddr) == 2'h2)
                & (addr_chan(paddr) == 2'(g));
            assign sel[g] = pcu_pkg::pcu_sel_t'(ctrl[g][`PCU_SEL_LO +: `PCU_SEL_W]);
            assign mode[g] = trig_mode(g, ctrl[g]);
            assign trig_cfg[g] = (mode[g] == pcu_pkg::MODE_TRIG) && (sel[g] != pcu_pkg::SEL_OFF);
            assign bad_cfg[g] = (mode[g] == pcu_pkg::MODE_BAD) && (sel[g] != pcu_pkg::SEL_OFF);

            // bad codes still index evcond, but only auto and trig modes arm
            assign start_go[g] = (mode[g] == pcu_pkg::MODE_AUTO) ? exec_start
                : evcond[ctrl[g][`PCU_START_LO +: `PCU_TRIG_W]];
            assign end_go[g] = (mode[g] == pcu_pkg::MODE_AUTO) ? (|evcond)
                : evcond[ctrl[g][`PCU_END_LO +: `PCU_TRIG_W]];

            pcu_event_sel i_pcu_event_sel (
                .pclk(pclk),
                .presetn(presetn),
                .evt(evt),
                .sel(sel[g]),
                .inc(inc[g])
            );

            // unused control bits read back as zero
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl[g] <= `PCU_CTRL_RST;
                end else if (ctrl_wr[g]) begin
                    ctrl[g] <= pwdata & 32'h000F_0F1F;
                end
            end

            // channels run independently, so four selections count at once
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    st[g] <= pcu_pkg::ST_IDLE;
                end else if (ctrl_wr[g]) begin
                    st[g] <= pcu_pkg::ST_IDLE;
                end else begin
                    case (st[g])
                        pcu_pkg::ST_IDLE: begin
                            if (sel[g] != pcu_pkg::SEL_OFF && mode[g] != pcu_pkg::MODE_BAD) begin
                                st[g] <= pcu_pkg::ST_ARMED;
                            end
                        end
                        pcu_pkg::ST_ARMED: begin
                            if (start_go[g]) begin
                                st[g] <= pcu_pkg::ST_COUNT;
                            end
                        end
                        pcu_pkg::ST_COUNT: begin
                            if (end_go[g]) begin
                                st[g] <= pcu_pkg::ST_DONE;
                            end
                        end
                        default: begin
                            if (cnt_rd[g]) begin
                                st[g] <= pcu_pkg::ST_ARMED;
                            end
                        end
                    endcase
                end
            end

            // the end cycle itself is not counted
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt[g] <= `PCU_CNT_RST;
                end else if (st[g] == pcu_pkg::ST_ARMED && start_go[g] && !ctrl_wr[g]) begin
                    cnt[g] <= `PCU_CNT_RST;
                end else if (st[g] == pcu_pkg::ST_COUNT && !end_go[g] && !ctrl_wr[g]) begin
                    cnt[g] <= cnt[g] + {29'h0, inc[g]};
                end
            end

            a_half_trig: assert property (@(posedge pclk) disable iff (!presetn)
                bad_cfg[g] |-> st[g] != pcu_pkg::ST_COUNT)
                else $error("half-configured channel counting");

            a_low_chan: assert property (@(posedge pclk) disable iff (!presetn)
                (g < 2 && ctrl[g][`PCU_START_LO +: `PCU_TRIG_W] == `PCU_TRIG_CH8)
                |-> mode[g] == pcu_pkg::MODE_BAD)
                else $error("low channel accepted condition eight");

            a_low_end: assert property (@(posedge pclk) disable iff (!presetn)
                (g < 2 && ctrl[g][`PCU_END_LO +: `PCU_TRIG_W] == `PCU_TRIG_CH9)
                |-> mode[g] == pcu_pkg::MODE_BAD)
                else $error("low channel accepted condition nine");

            a_start_clear: assert property (@(posedge pclk) disable iff (!presetn)
                (st[g] == pcu_pkg::ST_ARMED && start_go[g] && !ctrl_wr[g])
                |=> (st[g] == pcu_pkg::ST_COUNT && cnt[g] == 32'h0000_0000))
                else $error("start trigger did not clear and run");

            a_hold_done: assert property (@(posedge pclk) disable iff (!presetn)
                (st[g] == pcu_pkg::ST_DONE && !cnt_rd[g] && !ctrl_wr[g])
                |=> (st[g] == pcu_pkg::ST_DONE && $stable(cnt[g])))
                else $error("finished count not held");

            a_auto_stop: assert property (@(posedge pclk) disable iff (!presetn)
                (st[g] == pcu_pkg::ST_COUNT && mode[g] == pcu_pkg::MODE_AUTO
                && (|evcond) && !ctrl_wr[g]) |=> st[g] == pcu_pkg::ST_DONE)
                else $error("untriggered channel missed its stop");

            a_count_add: assert property (@(posedge pclk) disable iff (!presetn)
                (st[g] == pcu_pkg::ST_COUNT && !end_go[g] && !ctrl_wr[g])
                |=> cnt[g] == $past(cnt[g]) + {29'h0, $past(inc[g])})
                else $error("counter did not add the increment");

            a_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
                (sel[g] == pcu_pkg::SEL_OFF && st[g] == pcu_pkg::ST_IDLE && !ctrl_wr[g])
                |=> (st[g] == pcu_pkg::ST_IDLE && $stable(cnt[g])))
                else $error("disabled channel left idle");
        end
    endgenerate
endmodule
`default_nettype wire

// File: pcu_core_model.sv
// Purpose: core-side event source playing one fixed eight-cycle burst
// Assumes: burst rises just after a rising edge and stays up eight cycles
// Notes: quiet outside a burst, so idle cycles add nothing to any count except the elapsed-cycle selection
`timescale 1ns/1ps
`default_nettype none
module pcu_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic burst,
    output logic power_on_busy, priv_mode, exception_mask_bit, insn_done, dual_issue,
    output logic uncond_branch, branch_by_exc, exception_return, exc_accept, irq_accept,
    output logic nmi_accept, full_trace, stall_exec, evc_update, evc_tlb_fetch,
    output logic evc_tlb_operand, ftlb_miss, ftlb_valid, fetch_access, fetch_cancel,
    output logic icache_access,
    output logic [3:0] break_hit,
    output logic [3:0] stall_src
);
    logic [2:0] p;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p <= 3'h0;
        end else begin
            p <= burst ? p + 3'h1 : 3'h0;
        end
    end
    // events overlap on purpose: coincidences are where the selections differ
    assign power_on_busy = burst & (p == 3'h7);
    assign priv_mode = burst & (p < 3'h3);
    assign exception_mask_bit = burst & (p == 3'h1 | p == 3'h3);
    assign insn_done = burst;
    assign dual_issue = burst & (p < 3'h2);
    assign uncond_branch = burst & (p < 3'h4);
    assign branch_by_exc = burst & (p == 3'h1);
    assign exception_return = burst & (p == 3'h6);
    assign exc_accept = burst & (p == 3'h2);
    assign irq_accept = burst & (p == 3'h4);
    assign nmi_accept = burst & (p == 3'h5);
    assign break_hit = !burst ? 4'h0 : p == 3'h3 ? 4'h6 : p == 3'h4 ? 4'h1 : 4'h0;
    assign full_trace = burst & (p < 3'h6);
    // the all-sources stall falls outside full trace and must stay uncounted
    assign stall_src = !burst ? 4'h0 : p == 3'h1 ? 4'h3 : p == 3'h2 ? 4'h8 :
        p == 3'h6 ? 4'hF : 4'h0;
    assign stall_exec = burst & (p == 3'h2);
    assign evc_update = burst & p[0] & (p != 3'h7);
    assign evc_tlb_fetch = burst & (p < 3'h4);
    assign evc_tlb_operand = burst & (p > 3'h3);
    assign ftlb_miss = burst & (p < 3'h3);
    assign ftlb_valid = burst & (p != 3'h0);
    assign fetch_access = burst & (p < 3'h5);
    assign fetch_cancel = burst & p[2];
    assign icache_access = burst & (p == 3'h1 | p == 3'h3);
endmodule
`default_nettype wire

// File: pcu_top_bench.sv
// Purpose: register-level bench for the performance counter unit
// Assumes: one core-model burst gives a fixed count per selection
// Notes: counts are read some cycles after the end condition
`timescale 1ns/1ps
`default_nettype none
`include "pcu_regs.svh"
module pcu_top_bench;
    logic pclk, pready, pslverr, step_inhibit, err;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, exec_start = 1'b0;
    logic burst = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [12:0] evcond = 13'h0;
    logic power_on_busy, priv_mode, exception_mask_bit, insn_done, dual_issue, uncond_branch;
    logic branch_by_exc, exception_return, exc_accept, irq_accept, nmi_accept, full_trace;
    logic stall_exec, evc_update, evc_tlb_fetch, evc_tlb_operand, ftlb_miss, ftlb_valid;
    logic fetch_access, fetch_cancel, icache_access;
    logic [3:0] break_hit, stall_src;
    int fail_count = 0, tests_run = 0;
    logic [3:0] exp_cnt [16] = '{4'h7, 4'h3, 4'h2, 4'hA, 4'h2, 4'h4, 4'h3, 4'h2,
        4'h2, 4'h3, 4'h1, 4'h2, 4'h1, 4'h2, 4'h4, 4'h2};
    logic [3:0] gs [4] = '{4'h1, 4'h5, 4'h8, 4'hC};
    logic [3:0] ge [4] = '{4'h6, 4'h2, 4'h9, 4'hB};
    logic [3:0] bs [4] = '{4'h1, 4'h8, 4'h8, 4'h7};
    logic [3:0] be [4] = '{4'h0, 4'h9, 4'h9, 4'h3};
    pcu_core_model i_pcu_core_model (.pclk, .presetn, .burst, .power_on_busy, .priv_mode,
        .exception_mask_bit, .insn_done, .dual_issue, .uncond_branch, .branch_by_exc,
        .exception_return, .exc_accept, .irq_accept, .nmi_accept, .full_trace, .stall_exec,
        .evc_update, .evc_tlb_fetch, .evc_tlb_operand, .ftlb_miss, .ftlb_valid,
        .fetch_access, .fetch_cancel, .icache_access, .break_hit, .stall_src);
    pcu_top i_pcu_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .exec_start, .evcond, .power_on_busy, .priv_mode,
        .exception_mask_bit, .insn_done, .dual_issue, .uncond_branch, .branch_by_exc,
        .exception_return, .exc_accept, .irq_accept, .nmi_accept, .full_trace, .stall_exec,
        .evc_update, .evc_tlb_fetch, .evc_tlb_operand, .ftlb_miss, .ftlb_valid,
        .fetch_access, .fetch_cancel, .icache_access, .break_hit, .stall_src, .step_inhibit);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // request held until pready is sampled high; no fixed latency assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) fail_count++;
    endtask
    // start cycle, eight burst cycles, then the end cycle which is not counted
    task automatic run(input logic auto, input logic [12:0] s, input logic [12:0] e);
        @(posedge pclk);
        evcond <= s;
        exec_start <= auto;
        @(posedge pclk);
        evcond <= 13'h0;
        exec_start <= 1'b0;
        burst <= 1'b1;
        repeat (8) @(posedge pclk);
        burst <= 1'b0;
        evcond <= e;
        @(posedge pclk);
        evcond <= 13'h0;
    endtask
    function automatic logic [31:0] cw(logic [4:0] s, logic [3:0] a, logic [3:0] b);
        return {12'h000, b, 4'h0, a, 3'h0, s};
    endfunction
    function automatic logic [7:0] ca(int k);
        return `PCU_CTRL_BASE + 8'(k) * `PCU_CHAN_STRIDE;
    endfunction
    function automatic logic [7:0] na(int k);
        return `PCU_CNT_BASE + 8'(k) * `PCU_CHAN_STRIDE;
    endfunction
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ca(0), 32'h0);
        chk_word("ctrl reset", `PCU_CTRL_RST, rd);
        // one-sided, hole and channel-restricted trigger codes
        for (int k = 0; k < 4; k++) apb(1'b1, ca(k), cw(5'h01, bs[k], be[k]));
        apb(1'b0, `PCU_STATUS_OFS, 32'h0);
        chk_word("status", 32'h0000_1B00, rd & 32'h0000_1FFF);
        run(1'b0, 13'h0102, 13'h020C);
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, na(k), 32'h0);
            chk_word("bad config count", k == 2 ? 32'h7 : 32'h0, rd);
        end
        for (int g = 0; g < 4; g++) begin
            for (int k = 0; k < 4; k++) apb(1'b1, ca(k), cw(5'(4 * g + k + 1), gs[k], ge[k]));
            run(1'b0, 13'h1122, 13'h0A44);
            chk_word("inhibit", 32'h1, {31'h0, step_inhibit});
            repeat (4) @(posedge pclk);
            for (int k = 0; k < 4; k++) begin
                apb(1'b0, na(k), 32'h0);
                chk_word("count", {28'h0, exp_cnt[4 * g + k]}, rd);
            end
        end
        apb(1'b1, ca(0), cw(5'h01, 4'h0, 4'h0));
        apb(1'b1, ca(1), cw(5'h04, 4'h0, 4'h0));
        for (int k = 2; k < 4; k++) apb(1'b1, ca(k), 32'h0);
        run(1'b1, 13'h0000, 13'h0008);
        chk_word("auto inhibit", 32'h0, {31'h0, step_inhibit});
        apb(1'b0, na(0), 32'h0);
        chk_word("auto elapsed", 32'h7, rd);
        apb(1'b0, na(1), 32'h0);
        chk_word("auto insn", 32'hA, rd);
        apb(1'b0, 8'h24, 32'h0);
        chk_word("unmapped err", 32'h1, {31'h0, err});
        chk_word("unmapped data", 32'h0, rd);
        summarize();
    end
    initial begin
        #400000;
        fail_count++;
        summarize();
    end
endmodule
`default_nettype wire
